// file: hdl/mprs_cfg.svh
// Constants of the module power and restart sequencer
`ifndef MPRS_CFG_SVH
`define MPRS_CFG_SVH

// Clock rate in kHz, so that a time in ms times this gives cycles
`define MPRS_CLK_KHZ 50000
// Least low time of the power-on trigger, in ms
`define MPRS_TRIG_MIN_MS 300
// Least low time of the emergency reset line for a restart, in ms
`define MPRS_ERST_MIN_MS 200
// Low time of the emergency reset line that forces switch-off, in ms
`define MPRS_ERST_OFF_MS 8000
// Length of an orderly shutdown, in ms
`define MPRS_SHDN_MS 2000
// Cycles that the processor reset is held in the reset phase
`define MPRS_RST_HOLD_CYC 16'h0010
// Counter width for the long timers
`define MPRS_CNT_W 32

// Line indices of the interface line vector
`define MPRS_L_PRX 0
`define MPRS_L_PCTS 1
`define MPRS_L_PDSR 2
`define MPRS_L_PDCD 3
`define MPRS_L_PRING 4
`define MPRS_L_SRX 5
`define MPRS_L_SCTS 6
`define MPRS_L_AUDIN 7
`define MPRS_LINES 8

// First startup line levels and the handshake lines
`define MPRS_LINE_FIRST_LVL 8'hF9
`define MPRS_LINE_HS_MASK 8'h16
`define MPRS_LINE_SCTS_MASK 8'h40

`endif

// file: hdl/mprs_pkg.sv
// Types of the module power and restart sequencer
package mprs_pkg;

    // Power and sequencing states
    typedef enum logic [2:0] {
        MPRS_OFF = 3'h0,
        MPRS_STARTUP = 3'h1,
        MPRS_RESET = 3'h2,
        MPRS_FW_INIT = 3'h3,
        MPRS_READY = 3'h4,
        MPRS_SHUTDOWN = 3'h5
    } mprs_state_t;

endpackage

// file: hdl/mprs_top.sv
// Power, restart and line sequencing of a cellular module
//
// Contract
// - Power-on trigger is active low and starts the module from power-down.
// - Trigger low longer than 300 ms switches on; shorter pulses ignored.
// - Trigger tied low powers the module up each time supply appears.
// - Voltage or temperature out of range at startup switches off at once.
// - Emergency reset low over 200 ms resets processor and lines, restarting.
// - Emergency reset held low keeps the module restarting repeatedly.
// - Emergency reset low over 8000 ms switches the module off completely.
// - Emergency reset discards all volatile memory contents.
// - Firmware ready shown by primary CTS, DSR and ring driven low.
// - Reset phase: lines pulled down, secondary CTS high, one output line.
// - First startup drives RXD, DCD, ring, secondary RXD, audio high; the code pulls ring down until ready, then drives it low.
// - Line configuration from non-volatile store applies after power cycle.
// - Power-down keeps only the RTC regulator; software and lines inactive.
// - Airplane mode disables radio, logs off, rejects radio commands.
// - Functionality-reset command causes a software-controlled restart.
// - Fast-shutdown line low shuts the module down in hardware.
// - Critical temperature or under/overvoltage shuts the module down.
// - Commanded shutdown lasts 2 s, ended by supply indicator going low.
`include "mprs_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module mprs_top #(
    parameter logic [`MPRS_CNT_W-1:0] TRIG_MIN_CYC = `MPRS_CNT_W'(`MPRS_TRIG_MIN_MS * `MPRS_CLK_KHZ),
    parameter logic [`MPRS_CNT_W-1:0] ERST_MIN_CYC = `MPRS_CNT_W'(`MPRS_ERST_MIN_MS * `MPRS_CLK_KHZ),
    parameter logic [`MPRS_CNT_W-1:0] ERST_OFF_CYC = `MPRS_CNT_W'(`MPRS_ERST_OFF_MS * `MPRS_CLK_KHZ),
    parameter logic [`MPRS_CNT_W-1:0] SHDN_CYC = `MPRS_CNT_W'(`MPRS_SHDN_MS * `MPRS_CLK_KHZ)
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Supply and environment monitors
    input wire logic SUPPLY_OK,
    input wire logic VOLT_FAULT,
    input wire logic TEMP_FAULT,
    // Control pins from the host
    input wire logic POWER_ON_TRIGGER_N,
    input wire logic EMERGENCY_RESET_LINE_N,
    input wire logic FAST_SHUTDOWN_LINE_N,
    // Firmware and command interface
    input wire logic FW_INIT_DONE,
    input wire logic CMD_FUNC_RESET,
    input wire logic CMD_SHUTDOWN,
    input wire logic AIRPLANE_ON,
    input wire logic CMD_RADIO_REQ,
    input wire logic [`MPRS_LINES-1:0] NV_LINE_LEVEL,
    // Power domain controls
    output logic RTC_REG_ON,
    output logic CORE_POWER_ON,
    output logic PROC_RESET_N,
    output logic SW_RUN,
    output logic VOLATILE_CLEAR,
    output logic SUPPLY_OUTPUT_INDICATOR,
    // Status
    output logic FW_READY,
    output logic RADIO_EN,
    output logic NET_LOGOFF,
    output logic CMD_ACCEPT,
    output logic CMD_REJECT,
    output logic [2:0] STATE,
    // Interface lines
    output logic [`MPRS_LINES-1:0] LINE_OUT,
    output logic [`MPRS_LINES-1:0] LINE_OE,
    output logic [`MPRS_LINES-1:0] LINE_PD
);

    // Powered states in which the module reacts to its pins
    function automatic logic is_on(input mprs_pkg::mprs_state_t s);
        is_on = (s != mprs_pkg::MPRS_OFF);
    endfunction

    mprs_pkg::mprs_state_t state_ff;
    mprs_pkg::mprs_state_t nxt_state;
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic trig_low;
    logic erst_low;
    logic fst_low;
    logic [`MPRS_CNT_W-1:0] trig_cnt_ff;
    logic [`MPRS_CNT_W-1:0] erst_cnt_ff;
    logic [`MPRS_CNT_W-1:0] erst_seg_ff;
    logic [`MPRS_CNT_W-1:0] shdn_cnt_ff;
    logic [15:0] hold_cnt_ff;
    logic armed_ff;
    logic airplane_ff;
    logic [`MPRS_LINES-1:0] cfg_lvl_ff;
    logic fault;
    logic power_on_evt;
    logic erst_restart;
    logic erst_off;
    logic [`MPRS_LINES-1:0] nxt_oe;
    logic [`MPRS_LINES-1:0] nxt_out;
    logic [`MPRS_LINES-1:0] nxt_pd;

    // Two-flop synchronisers; idle level of every pin is high
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    sync1_ff[gi] <= 1'b1;
                    sync2_ff[gi] <= 1'b1;
                end else begin
                    sync1_ff[gi] <= (gi == 0) ? POWER_ON_TRIGGER_N :
                                    (gi == 1) ? EMERGENCY_RESET_LINE_N : FAST_SHUTDOWN_LINE_N;
                    sync2_ff[gi] <= sync1_ff[gi];
                end
            end
        end
    endgenerate

    assign trig_low = !sync2_ff[0];
    assign erst_low = !sync2_ff[1];
    assign fst_low = !sync2_ff[2];
    assign fault = VOLT_FAULT || TEMP_FAULT;

    // Trigger low time; the count restarts on every release
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            trig_cnt_ff <= '0;
        end else if (!trig_low || !SUPPLY_OK) begin
            trig_cnt_ff <= '0;
        end else if (trig_cnt_ff != '1) begin
            trig_cnt_ff <= trig_cnt_ff + `MPRS_CNT_W'(1);
        end
    end

    // Emergency reset total low time, saturating
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            erst_cnt_ff <= '0;
        end else if (!erst_low) begin
            erst_cnt_ff <= '0;
        end else if (erst_cnt_ff != '1) begin
            erst_cnt_ff <= erst_cnt_ff + `MPRS_CNT_W'(1);
        end
    end

    // Low time since the last restart; restarting again needs a fresh 200 ms
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            erst_seg_ff <= '0;
        end else if (!erst_low || erst_restart) begin
            erst_seg_ff <= '0;
        end else if (erst_seg_ff != '1) begin
            erst_seg_ff <= erst_seg_ff + `MPRS_CNT_W'(1);
        end
    end

    // Long hold wins over a restart, so a stuck line ends switched off
    assign erst_off = is_on(state_ff) && erst_low && (erst_cnt_ff > ERST_OFF_CYC);
    assign erst_restart = is_on(state_ff) && erst_low && !erst_off &&
                          (erst_seg_ff > ERST_MIN_CYC);
    // A permanently low trigger must not re-launch right after a shutdown
    assign power_on_evt = (state_ff == mprs_pkg::MPRS_OFF) && SUPPLY_OK && armed_ff &&
                          (trig_cnt_ff > TRIG_MIN_CYC);

    // Power-on arming: renewed by a trigger release or a supply cycle
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            armed_ff <= 1'b1;
        end else if (!SUPPLY_OK || !trig_low) begin
            armed_ff <= 1'b1;
        end else if (power_on_evt) begin
            armed_ff <= 1'b0;
        end
    end

    // Sequencer; supply loss overrides everything, hardware shutdown everything once powered up (not a power-on event)
    always_comb begin
        nxt_state = state_ff;
        if (!SUPPLY_OK) begin
            nxt_state = mprs_pkg::MPRS_OFF;
        end else if (is_on(state_ff) && fst_low) begin
            nxt_state = mprs_pkg::MPRS_OFF;
        end else if (erst_off) begin
            nxt_state = mprs_pkg::MPRS_OFF;
        end else if (erst_restart) begin
            nxt_state = mprs_pkg::MPRS_RESET;
        end else begin
            unique case (state_ff)
                mprs_pkg::MPRS_OFF: begin
                    if (power_on_evt) begin
                        nxt_state = mprs_pkg::MPRS_STARTUP;
                    end
                end
                mprs_pkg::MPRS_STARTUP: begin
                    nxt_state = fault ? mprs_pkg::MPRS_OFF : mprs_pkg::MPRS_RESET;
                end
                mprs_pkg::MPRS_RESET: begin
                    if (hold_cnt_ff >= `MPRS_RST_HOLD_CYC) begin
                        nxt_state = mprs_pkg::MPRS_FW_INIT;
                    end
                end
                mprs_pkg::MPRS_FW_INIT: begin
                    if (fault) begin
                        nxt_state = mprs_pkg::MPRS_SHUTDOWN;
                    end else if (FW_INIT_DONE) begin
                        nxt_state = mprs_pkg::MPRS_READY;
                    end
                end
                mprs_pkg::MPRS_READY: begin
                    if (fault || CMD_SHUTDOWN) begin
                        nxt_state = mprs_pkg::MPRS_SHUTDOWN;
                    end else if (CMD_FUNC_RESET) begin
                        nxt_state = mprs_pkg::MPRS_RESET;
                    end
                end
                mprs_pkg::MPRS_SHUTDOWN: begin
                    if (shdn_cnt_ff >= SHDN_CYC) begin
                        nxt_state = mprs_pkg::MPRS_OFF;
                    end
                end
                default: begin
                    nxt_state = mprs_pkg::MPRS_OFF;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_ff <= mprs_pkg::MPRS_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Reset-phase and shutdown timers, cleared on entry
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            hold_cnt_ff <= '0;
            shdn_cnt_ff <= '0;
        end else begin
            hold_cnt_ff <= (state_ff == mprs_pkg::MPRS_RESET && nxt_state == mprs_pkg::MPRS_RESET) ?
                           hold_cnt_ff + 16'h0001 : 16'h0000;
            shdn_cnt_ff <= (state_ff == mprs_pkg::MPRS_SHUTDOWN) ?
                           shdn_cnt_ff + `MPRS_CNT_W'(1) : '0;
        end
    end

    // Stored line levels are taken only when the module powers up
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cfg_lvl_ff <= `MPRS_LINE_FIRST_LVL;
        end else if (power_on_evt) begin
            cfg_lvl_ff <= NV_LINE_LEVEL;
        end
    end

    // Airplane mode follows the command level while running
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            airplane_ff <= 1'b0;
            NET_LOGOFF <= 1'b0;
        end else begin
            airplane_ff <= (state_ff == mprs_pkg::MPRS_READY) && AIRPLANE_ON;
            NET_LOGOFF <= (state_ff == mprs_pkg::MPRS_READY) && AIRPLANE_ON && !airplane_ff;
        end
    end

    // Command answers: radio requests refused in airplane mode
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            CMD_ACCEPT <= 1'b0;
            CMD_REJECT <= 1'b0;
        end else begin
            CMD_ACCEPT <= CMD_RADIO_REQ && (state_ff == mprs_pkg::MPRS_READY) && !airplane_ff;
            CMD_REJECT <= CMD_RADIO_REQ && !((state_ff == mprs_pkg::MPRS_READY) && !airplane_ff);
        end
    end

    // Line pattern per state; handshake lines wait for firmware ready
    always_comb begin
        nxt_oe = '0;
        nxt_out = '0;
        nxt_pd = '0;
        unique case (state_ff)
            mprs_pkg::MPRS_OFF: begin
                nxt_oe = '0;
            end
            mprs_pkg::MPRS_FW_INIT: begin
                nxt_oe = ~`MPRS_LINE_HS_MASK;
                nxt_out = cfg_lvl_ff & ~`MPRS_LINE_HS_MASK;
                nxt_pd = `MPRS_LINE_HS_MASK;
            end
            mprs_pkg::MPRS_READY: begin
                nxt_oe = '1;
                nxt_out = cfg_lvl_ff & ~`MPRS_LINE_HS_MASK;
            end
            default: begin
                nxt_oe = `MPRS_LINE_SCTS_MASK;
                nxt_out = `MPRS_LINE_SCTS_MASK;
                nxt_pd = ~`MPRS_LINE_SCTS_MASK;
            end
        endcase
    end

    // Registered line and power outputs
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            LINE_OE <= '0;
            LINE_OUT <= '0;
            LINE_PD <= '0;
            RTC_REG_ON <= 1'b0;
            CORE_POWER_ON <= 1'b0;
            PROC_RESET_N <= 1'b0;
            SW_RUN <= 1'b0;
            SUPPLY_OUTPUT_INDICATOR <= 1'b0;
            FW_READY <= 1'b0;
            RADIO_EN <= 1'b0;
            VOLATILE_CLEAR <= 1'b0;
            STATE <= 3'h0;
        end else begin
            LINE_OE <= nxt_oe;
            LINE_OUT <= nxt_out;
            LINE_PD <= nxt_pd;
            RTC_REG_ON <= SUPPLY_OK;
            CORE_POWER_ON <= is_on(state_ff);
            PROC_RESET_N <= is_on(state_ff) && (state_ff != mprs_pkg::MPRS_RESET) &&
                            (state_ff != mprs_pkg::MPRS_STARTUP);
            SW_RUN <= (state_ff == mprs_pkg::MPRS_FW_INIT) || (state_ff == mprs_pkg::MPRS_READY) ||
                      (state_ff == mprs_pkg::MPRS_SHUTDOWN);
            SUPPLY_OUTPUT_INDICATOR <= is_on(state_ff);
            FW_READY <= (state_ff == mprs_pkg::MPRS_READY);
            RADIO_EN <= (state_ff == mprs_pkg::MPRS_READY) && !airplane_ff;
            VOLATILE_CLEAR <= erst_restart;
            STATE <= state_ff;
        end
    end

    // Checks on the sequencer
    a_trig_min_width: assert property (@(posedge CLK) disable iff (!RESET_N)
        (state_ff == mprs_pkg::MPRS_OFF) && (nxt_state == mprs_pkg::MPRS_STARTUP) |->
        (trig_cnt_ff > TRIG_MIN_CYC) && SUPPLY_OK)
        else $error("power-on without a long enough trigger pulse");

    a_startup_fault_off: assert property (@(posedge CLK) disable iff (!RESET_N)
        (state_ff == mprs_pkg::MPRS_STARTUP) && fault && !erst_restart |=> state_ff == mprs_pkg::MPRS_OFF)
        else $error("fault at startup did not switch off");

    a_erst_restart: assert property (@(posedge CLK) disable iff (!RESET_N)
        erst_restart && SUPPLY_OK && !fst_low |=> (state_ff == mprs_pkg::MPRS_RESET) && VOLATILE_CLEAR)
        else $error("emergency reset did not restart");

    a_erst_repeat: assert property (@(posedge CLK) disable iff (!RESET_N)
        erst_restart |=> (erst_seg_ff == '0))
        else $error("restart segment not restarted");

    a_erst_off: assert property (@(posedge CLK) disable iff (!RESET_N)
        erst_off |=> (state_ff == mprs_pkg::MPRS_OFF) ##1 !CORE_POWER_ON)
        else $error("long emergency hold did not switch off");

    a_fast_shutdown: assert property (@(posedge CLK) disable iff (!RESET_N)
        is_on(state_ff) && fst_low |=> state_ff == mprs_pkg::MPRS_OFF)
        else $error("fast shutdown ignored");

    a_hs_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
        state_ff != mprs_pkg::MPRS_READY |=> (LINE_OE & `MPRS_LINE_HS_MASK) == 8'h00)
        else $error("handshake line driven before firmware ready");

    a_ready_lines: assert property (@(posedge CLK) disable iff (!RESET_N)
        state_ff == mprs_pkg::MPRS_READY |=> FW_READY && ((LINE_OE & `MPRS_LINE_HS_MASK) == `MPRS_LINE_HS_MASK)
        && ((LINE_OUT & `MPRS_LINE_HS_MASK) == 8'h00))
        else $error("handshake lines not low when ready");

    a_pdown_quiet: assert property (@(posedge CLK) disable iff (!RESET_N)
        state_ff == mprs_pkg::MPRS_OFF |=> !CORE_POWER_ON && !SW_RUN && (LINE_OE == 8'h00))
        else $error("power-down not quiet");

    a_airplane_reject: assert property (@(posedge CLK) disable iff (!RESET_N)
        airplane_ff && CMD_RADIO_REQ |=> CMD_REJECT && !CMD_ACCEPT && !RADIO_EN)
        else $error("radio command accepted in airplane mode");

    a_shutdown_end: assert property (@(posedge CLK) disable iff (!RESET_N)
        (state_ff == mprs_pkg::MPRS_SHUTDOWN) && (shdn_cnt_ff < SHDN_CYC) && SUPPLY_OK && !fst_low && !erst_low
        |=> SUPPLY_OUTPUT_INDICATOR)
        else $error("supply indicator dropped before shutdown end");

    a_cfg_stable: assert property (@(posedge CLK) disable iff (!RESET_N)
        is_on(state_ff) |=> $stable(cfg_lvl_ff))
        else $error("line configuration changed while powered");

endmodule

`default_nettype wire

// file: tb/mprs_host_model.sv
// Host model that drives the module's control lines
`timescale 1ns/100ps
`default_nettype none

module mprs_host_model (
    // Clock
    input wire logic clk,
    // Lines toward the module
    output var logic supply_ok,
    output var logic trig_n,
    output var logic erst_n,
    output var logic fsd_n
);
    // Supply is up before any line moves; lines idle high
    initial begin
        supply_ok = 1'b1;
        trig_n = 1'b1;
        erst_n = 1'b1;
        fsd_n = 1'b1;
    end

    // One line change just after an edge (supply and trigger together for any other sel), held until the next call
    task automatic drive(input int sel, input logic v);
        @(posedge clk);
        case (sel)
            0: supply_ok <= v;
            1: trig_n <= supply_ok ? v : 1'b1; // No trigger without supply
            2: erst_n <= v; // Last resort only, once software is silent
            3: fsd_n <= v;
            default: begin
                supply_ok <= 1'b1;
                trig_n <= 1'b0; // Trigger pulled low as supply appears
            end
        endcase
    endtask
endmodule

`default_nettype wire

// file: tb/mprs_top_tb.sv
// Self-checking bench of the power and restart sequencer
`timescale 1ns/100ps
`default_nettype none

module mprs_top_tb;
    // Bench state
    logic clk, reset_n;
    int errors, checks, clears, logoffs;
    logic [7:0] seen;
    // Design inputs and outputs
    logic supply_ok, trig_n, erst_n, fsd_n, volt_fault, temp_fault, fw_done, func_rst, shdn_cmd, airplane, radio_req;
    logic [7:0] nv_lvl, line_out, line_oe, line_pd;
    logic rtc_on, core_on, proc_rst_n, sw_run, vol_clear, ind, fw_ready, radio_en, logoff, cmd_acc, cmd_rej;
    logic [2:0] state;
    // Short state names
    localparam logic [2:0] ST_OFF = mprs_pkg::MPRS_OFF;
    localparam logic [2:0] ST_RST = mprs_pkg::MPRS_RESET;
    localparam logic [2:0] ST_INIT = mprs_pkg::MPRS_FW_INIT;
    localparam logic [2:0] ST_READY = mprs_pkg::MPRS_READY;
    localparam logic [2:0] ST_SHDN = mprs_pkg::MPRS_SHUTDOWN;

    // Short counts keep the run brief
    mprs_top #(.TRIG_MIN_CYC(32'h0000_0014), .ERST_MIN_CYC(32'h0000_000A), .ERST_OFF_CYC(32'h0000_0064),
        .SHDN_CYC(32'h0000_001E)) u_mprs_top (
        .CLK(clk), .RESET_N(reset_n), .SUPPLY_OK(supply_ok), .VOLT_FAULT(volt_fault), .TEMP_FAULT(temp_fault),
        .POWER_ON_TRIGGER_N(trig_n), .EMERGENCY_RESET_LINE_N(erst_n), .FAST_SHUTDOWN_LINE_N(fsd_n),
        .FW_INIT_DONE(fw_done), .CMD_FUNC_RESET(func_rst), .CMD_SHUTDOWN(shdn_cmd), .AIRPLANE_ON(airplane),
        .CMD_RADIO_REQ(radio_req), .NV_LINE_LEVEL(nv_lvl), .RTC_REG_ON(rtc_on), .CORE_POWER_ON(core_on),
        .PROC_RESET_N(proc_rst_n), .SW_RUN(sw_run), .VOLATILE_CLEAR(vol_clear), .SUPPLY_OUTPUT_INDICATOR(ind),
        .FW_READY(fw_ready), .RADIO_EN(radio_en), .NET_LOGOFF(logoff), .CMD_ACCEPT(cmd_acc), .CMD_REJECT(cmd_rej),
        .STATE(state), .LINE_OUT(line_out), .LINE_OE(line_oe), .LINE_PD(line_pd));
    mprs_host_model u_mprs_host_model (.clk(clk), .supply_ok(supply_ok), .trig_n(trig_n), .erst_n(erst_n),
        .fsd_n(fsd_n));

    // Clock at 50 MHz
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Pulse tallies and visited states, sampled mid-cycle
    always @(negedge clk) begin
        if (vol_clear === 1'b1) clears++;
        if (logoff === 1'b1) logoffs++;
        if (state !== 3'bxxx) seen[state] = 1'b1;
    end

    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic final_report();
        if (errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Bounded wait for a state; a miss ends the run
    task automatic wait_st(input logic [2:0] s, input int n);
        int i;
        @(negedge clk);
        for (i = 0; i < n && state !== s; i++) begin
            @(negedge clk);
        end
        chk("state", state, s);
        if (state !== s) final_report();
    endtask

    task automatic drv(input int sel, input logic v);
        u_mprs_host_model.drive(sel, v);
    endtask

    task automatic trig(input int n);
        drv(1, 1'b0);
        repeat (n - 1) @(posedge clk);
        drv(1, 1'b1);
    endtask

    // One-cycle command pulse
    task automatic pulse(input int sel);
        @(posedge clk);
        case (sel)
            0: fw_done <= 1'b1;
            1: func_rst <= 1'b1;
            2: shdn_cmd <= 1'b1;
            default: radio_req <= 1'b1;
        endcase
        @(posedge clk);
        {fw_done, func_rst, shdn_cmd, radio_req} <= 4'h0;
    endtask

    // Room for a full power-on plus the reset phase when the trigger is tied low
    task automatic finish_init();
        wait_st(ST_INIT, 60);
        pulse(0);
        wait_st(ST_READY, 5);
    endtask

    task automatic power_up();
        trig(40);
        finish_init();
    endtask

    task automatic sc_power_on();
        chk("idle", {rtc_on, core_on, ind, line_oe[4:0]}, 8'h80);
        trig(20);
        repeat (10) @(negedge clk);
        chk("short trigger", state, ST_OFF);
        drv(1, 1'b0);
        wait_st(ST_RST, 40);
        @(negedge clk);
        chk("reset oe", line_oe, 8'h40);
        chk("reset out", line_out, 8'h40);
        chk("reset pd", line_pd, 8'hBF);
        chk("proc reset", proc_rst_n, 1'b0);
        @(posedge clk);
        nv_lvl <= 8'h08;
        drv(1, 1'b1);
        wait_st(ST_INIT, 40);
        @(negedge clk);
        chk("init oe", line_oe, 8'hE9);
        chk("init out", line_out & 8'hE9, 8'hE9);
        chk("init hs", {3'h0, fw_ready, line_pd[4:1]}, 8'h0B);
        pulse(0);
        wait_st(ST_READY, 5);
        @(negedge clk);
        chk("ready oe", line_oe, 8'hFF);
        chk("ready out", line_out, 8'hE9);
        chk("ready flags", {fw_ready, sw_run}, 8'h03);
    endtask

    task automatic sc_radio_restart();
        int c0;
        pulse(3);
        @(negedge clk);
        chk("accept", {cmd_acc, cmd_rej, radio_en}, 8'h05);
        @(posedge clk);
        airplane <= 1'b1;
        repeat (4) @(negedge clk);
        chk("logoff", {radio_en, 7'(logoffs)}, 8'h01);
        pulse(3);
        @(negedge clk);
        chk("reject", {cmd_acc, cmd_rej}, 8'h01);
        @(posedge clk);
        airplane <= 1'b0;
        c0 = clears;
        pulse(1);
        wait_st(ST_RST, 5);
        chk("sw clear", 8'(clears - c0), 8'h00);
        finish_init();
    endtask

    // Held reset restarts repeatedly, then forces switch-off
    task automatic sc_emergency();
        int i;
        int c0;
        c0 = clears;
        drv(2, 1'b0);
        for (i = 0; i < 200 && state !== ST_OFF; i++) begin
            @(negedge clk);
        end
        chk("off delay", 8'(i >= 100 && i <= 110), 8'h01);
        chk("restarts", 8'(clears - c0 >= 7 && clears - c0 <= 10), 8'h01);
        if (i >= 200) final_report();
        drv(2, 1'b1);
        repeat (20) @(negedge clk);
        chk("stays off", state, ST_OFF);
    endtask

    task automatic sc_shutdowns();
        int i;
        power_up();
        @(negedge clk);
        chk("new level", line_out, 8'h08);
        drv(3, 1'b0);
        wait_st(ST_OFF, 6);
        drv(3, 1'b1);
        power_up();
        pulse(2);
        wait_st(ST_SHDN, 5);
        for (i = 0; i < 60 && ind === 1'b1; i++) begin
            @(negedge clk);
        end
        chk("shutdown len", 8'(i >= 28 && i <= 34), 8'h01);
        if (i >= 60) final_report();
        chk("power down", {state, rtc_on, core_on, sw_run, line_oe[1:0]}, 8'h10);
    endtask

    task automatic sc_faults();
        @(posedge clk);
        temp_fault <= 1'b1;
        seen = 8'h00;
        trig(40);
        repeat (5) @(negedge clk);
        chk("startup fault", seen & 8'h06, 8'h02);
        @(posedge clk);
        temp_fault <= 1'b0;
        power_up();
        @(posedge clk);
        volt_fault <= 1'b1;
        wait_st(ST_SHDN, 5);
        wait_st(ST_OFF, 40);
        @(posedge clk);
        volt_fault <= 1'b0;
    endtask

    // Trigger tied low: each supply application powers up
    task automatic sc_tied();
        drv(0, 1'b0);
        drv(4, 1'b1);
        finish_init();
        drv(0, 1'b0);
        wait_st(ST_OFF, 3);
        drv(0, 1'b1);
        finish_init();
        drv(1, 1'b1);
    endtask

    // Main sequence
    initial begin
        errors = 0;
        checks = 0;
        clears = 0;
        logoffs = 0;
        seen = 8'h00;
        {volt_fault, temp_fault, fw_done, func_rst, shdn_cmd, airplane, radio_req} = 7'h00;
        nv_lvl = 8'hF9;
        reset_n = 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(negedge clk);
        sc_power_on();
        sc_radio_restart();
        sc_emergency();
        sc_shutdowns();
        sc_faults();
        sc_tied();
        final_report();
    end
endmodule

`default_nettype wire
